// file: rtl/vout_limits_params.svh
`ifndef VOUT_LIMITS_PARAMS_SVH
`define VOUT_LIMITS_PARAMS_SVH

// ----------------------------------------------------------------------------
// Command codes and paging
// ----------------------------------------------------------------------------
`define CMD_OV_FAULT_ACTION 8'h41
`define CMD_OV_WARNING_LIMIT 8'h42
`define CMD_UV_WARNING_LIMIT 8'h43
`define PAGE_ALL 8'hFF
`define NUM_PAGES 2

// ----------------------------------------------------------------------------
// Overvoltage fault action byte layout and encodings
// ----------------------------------------------------------------------------
`define ACTION_MSB 7
`define ACTION_LSB 6
`define POLICY_MSB 5
`define POLICY_LSB 3
`define ACTION_CONTINUE 2'h0
`define ACTION_SHUTDOWN 2'h2
`define POLICY_LATCH 3'h0
`define POLICY_HICCUP 3'h7

// ----------------------------------------------------------------------------
// Tracking offset steps
// ----------------------------------------------------------------------------
// One step is 8 mV; with one code per mV a step is 1 << 3 codes
`define STEP_MV 8
`define STEP_SHIFT 3
`define MIN_STEPS 6'h01
`define MAX_STEPS 6'h38

// ----------------------------------------------------------------------------
// Reset values standing in for the nonvolatile copy
// ----------------------------------------------------------------------------
`define RST_ACTION 2'h2
`define RST_POLICY 3'h7
`define RST_OV_STEPS 6'h08
`define RST_UV_STEPS 6'h08

`endif

// file: rtl/vout_limits_pkg.sv
package vout_limits_pkg;

    typedef logic [15:0] word_t;
    typedef logic [5:0] steps_t;
    typedef logic [16:0] diff_t;

endpackage : vout_limits_pkg

// file: rtl/vout_ov_uv_limit_commands.sv
// Behaviour
// - Paged byte command 41h selects overvoltage handling
// - Overvoltage fault sets fault, summary flags; notify
// - Action 00 continue, 10 shutdown, others rejected
// - Retry 0 latches off, 7 hiccups until off/start
// - Unsupported values written to 41h-43h flag invalid data and notify
// - Paged 16-bit warning limits at 42h, 43h
// - Page FFh updates valid channel, may refuse
// - Limit write stores its offset from the voltage command (OV: limit minus command, UV: command minus limit)
// - Reported limit follows voltage command, offset kept
// - Overvoltage offset 8 to 448 mV, 8 mV steps
// - Undervoltage offset 8 to 448 mV, 8 mV steps
// - Zero boot voltage selects widest 448 mV offsets
// - Conversion ignores droop, trim; loop scale one
// - Overvoltage warning crossing sets flags and notifies
// - Undervoltage warning crossing sets flags and notifies
`timescale 1ns/1ps
`include "vout_limits_params.svh"

module vout_ov_uv_limit_commands
    import vout_limits_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic link_clk,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [7:0] req_code,
    input wire logic [7:0] req_page,
    input wire logic [15:0] req_wdata,
    output logic req_busy,
    output logic rsp_valid,
    output logic [15:0] rsp_rdata,
    output logic rsp_nack,
    input wire logic [`NUM_PAGES-1:0][15:0] vout_command,
    input wire logic [`NUM_PAGES-1:0][15:0] boot_voltage_setting,
    input wire logic [`NUM_PAGES-1:0] ov_fault_sense,
    input wire logic [`NUM_PAGES-1:0] ov_warn_sense,
    input wire logic [`NUM_PAGES-1:0] uv_warn_sense,
    input wire logic [`NUM_PAGES-1:0] output_on,
    input wire logic [`NUM_PAGES-1:0] startup_ok,
    input wire logic [`NUM_PAGES-1:0] status_clear,
    output logic [`NUM_PAGES-1:0] ov_fault_summary_flag,
    output logic [`NUM_PAGES-1:0] vout_summary_flag,
    output logic [`NUM_PAGES-1:0] ov_fault_flag,
    output logic [`NUM_PAGES-1:0] ov_warning_flag,
    output logic [`NUM_PAGES-1:0] uv_warning_flag,
    output logic [`NUM_PAGES-1:0] invalid_data_flag,
    output logic [`NUM_PAGES-1:0] output_shutdown,
    output logic [`NUM_PAGES-1:0] hiccup_retry,
    output logic [`NUM_PAGES-1:0][5:0] ov_warning_value,
    output logic [`NUM_PAGES-1:0][5:0] uv_warning_value,
    output logic notify_host
);

    // ------------------------------------------------------------------------
    // Offset check shared by both warning limits
    // ------------------------------------------------------------------------
    // Returns {valid, steps}; the difference must be a whole number of steps
    function automatic logic [6:0] check_offset(input diff_t diff);
        diff_t q;
        logic ok;
        q = diff >> `STEP_SHIFT;
        ok = !diff[16] && (diff[`STEP_SHIFT-1:0] == '0) &&
             (q >= 17'(`MIN_STEPS)) && (q <= 17'(`MAX_STEPS));
        return {ok, q[5:0]};
    endfunction : check_offset

    // ------------------------------------------------------------------------
    // Link domain: request capture and answer
    // ------------------------------------------------------------------------
    logic lrst_meta_q;
    logic lrst_q;
    logic busy_q;
    logic req_tgl_q;
    logic l_write_q;
    logic [7:0] l_code_q;
    logic [7:0] l_page_q;
    logic [15:0] l_wdata_q;
    logic ack_meta_q;
    logic ack_s1_q;
    logic ack_s2_q;
    logic ack_event;
    logic rsp_valid_q;
    logic [15:0] rsp_rdata_q;
    logic rsp_nack_q;
    logic ack_tgl_q;
    logic [15:0] core_rdata_q;
    logic core_nack_q;

    // Reset is carried into the link domain as a level
    always_ff @(posedge link_clk) begin
        lrst_meta_q <= srst;
        lrst_q <= lrst_meta_q;
    end

    always_ff @(posedge link_clk) begin
        if (lrst_q) begin
            ack_meta_q <= 1'b0;
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
        end else begin
            ack_meta_q <= ack_tgl_q;
            ack_s1_q <= ack_meta_q;
            ack_s2_q <= ack_s1_q;
        end
    end

    assign ack_event = ack_s1_q ^ ack_s2_q;

    // Fields are held while busy so the core may read them after the toggle
    always_ff @(posedge link_clk) begin
        if (lrst_q) begin
            busy_q <= 1'b0;
            req_tgl_q <= 1'b0;
            l_write_q <= 1'b0;
            l_code_q <= 8'h00;
            l_page_q <= 8'h00;
            l_wdata_q <= 16'h0000;
        end else if (req_valid && !busy_q) begin
            busy_q <= 1'b1;
            req_tgl_q <= ~req_tgl_q;
            l_write_q <= req_write;
            l_code_q <= req_code;
            l_page_q <= req_page;
            l_wdata_q <= req_wdata;
        end else if (ack_event) begin
            busy_q <= 1'b0;
        end
    end

    always_ff @(posedge link_clk) begin
        if (lrst_q) begin
            rsp_valid_q <= 1'b0;
            rsp_rdata_q <= 16'h0000;
            rsp_nack_q <= 1'b0;
        end else begin
            rsp_valid_q <= ack_event;
            if (ack_event) begin
                rsp_rdata_q <= core_rdata_q;
                rsp_nack_q <= core_nack_q;
            end
        end
    end

    assign req_busy = busy_q;
    assign rsp_valid = rsp_valid_q;
    assign rsp_rdata = rsp_rdata_q;
    assign rsp_nack = rsp_nack_q;

    // ------------------------------------------------------------------------
    // Core domain: request arrival
    // ------------------------------------------------------------------------
    logic req_meta_q;
    logic req_s1_q;
    logic req_s2_q;
    logic access;
    logic boot_done_q;
    logic page_all;
    logic page_bad;
    logic code_bad;
    logic rd_page;
    logic [`NUM_PAGES-1:0] chan_sel;
    logic [`NUM_PAGES-1:0] chan_bad;
    logic [15:0] rd_word [`NUM_PAGES];

    always_ff @(posedge clk) begin
        if (srst) begin
            req_meta_q <= 1'b0;
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
        end else if (ce) begin
            req_meta_q <= req_tgl_q;
            req_s1_q <= req_meta_q;
            req_s2_q <= req_s1_q;
        end
    end

    assign access = ce && (req_s1_q ^ req_s2_q);
    assign page_all = (l_page_q == `PAGE_ALL);
    assign page_bad = !page_all && (l_page_q >= 8'(`NUM_PAGES));
    assign code_bad = (l_code_q != `CMD_OV_FAULT_ACTION) &&
                      (l_code_q != `CMD_OV_WARNING_LIMIT) &&
                      (l_code_q != `CMD_UV_WARNING_LIMIT);
    // A broadcast read answers from the first page
    assign rd_page = page_all ? 1'b0 : l_page_q[0];

    always_ff @(posedge clk) begin
        if (srst) begin
            boot_done_q <= 1'b0;
        end else if (ce) begin
            boot_done_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Per page command registers, status and fault handling
    // ------------------------------------------------------------------------
    for (genvar g = 0; g < `NUM_PAGES; g++) begin : g_page
        logic [1:0] action_q;
        logic [2:0] policy_q;
        steps_t ov_steps_q;
        steps_t uv_steps_q;
        logic [2:0] sense_meta_q;
        logic [2:0] sense_s1_q;
        logic [2:0] sense_s2_q;
        logic ov_fault_rise;
        logic ov_warn_rise;
        logic uv_warn_rise;
        logic act_ok;
        logic [6:0] ov_chk;
        logic [6:0] uv_chk;
        logic wr_act;
        logic wr_ov;
        logic wr_uv;
        logic shut_q;
        logic retry_q;
        logic [5:0] flags_q;

        assign chan_sel[g] = access && l_write_q && !code_bad && (page_all || l_page_q == 8'(g));

        // Continue or shutdown only, latch or hiccup only; low bits are don't care
        assign act_ok = (l_wdata_q[`ACTION_MSB:`ACTION_LSB] == `ACTION_CONTINUE ||
                         l_wdata_q[`ACTION_MSB:`ACTION_LSB] == `ACTION_SHUTDOWN) &&
                        (l_wdata_q[`POLICY_MSB:`POLICY_LSB] == `POLICY_LATCH ||
                         l_wdata_q[`POLICY_MSB:`POLICY_LSB] == `POLICY_HICCUP);
        // Offsets taken against today's command, no droop or trim term
        assign ov_chk = check_offset({1'b0, l_wdata_q} - {1'b0, vout_command[g]});
        assign uv_chk = check_offset({1'b0, vout_command[g]} - {1'b0, l_wdata_q});

        assign wr_act = chan_sel[g] && l_code_q == `CMD_OV_FAULT_ACTION && act_ok;
        assign wr_ov = chan_sel[g] && l_code_q == `CMD_OV_WARNING_LIMIT && ov_chk[6];
        assign wr_uv = chan_sel[g] && l_code_q == `CMD_UV_WARNING_LIMIT && uv_chk[6];
        assign chan_bad[g] = chan_sel[g] && !wr_act && !wr_ov && !wr_uv;

        always_ff @(posedge clk) begin
            if (srst) begin
                action_q <= `RST_ACTION;
                policy_q <= `RST_POLICY;
            end else if (ce && wr_act) begin
                action_q <= l_wdata_q[`ACTION_MSB:`ACTION_LSB];
                policy_q <= l_wdata_q[`POLICY_MSB:`POLICY_LSB];
            end
        end

        // A broadcast write lands on every page where it is valid
        always_ff @(posedge clk) begin
            if (srst) begin
                ov_steps_q <= `RST_OV_STEPS;
                uv_steps_q <= `RST_UV_STEPS;
            end else if (ce) begin
                if (!boot_done_q && boot_voltage_setting[g] == 16'h0000) begin
                    ov_steps_q <= `MAX_STEPS;
                    uv_steps_q <= `MAX_STEPS;
                end else begin
                    if (wr_ov) begin
                        ov_steps_q <= ov_chk[5:0];
                    end
                    if (wr_uv) begin
                        uv_steps_q <= uv_chk[5:0];
                    end
                end
            end
        end

        // Reported limit words are rebuilt from the live command on every read
        always_comb begin
            rd_word[g] = 16'h0000;
            unique case (l_code_q)
                `CMD_OV_FAULT_ACTION: rd_word[g] = {8'h00, action_q, policy_q, 3'h0};
                `CMD_OV_WARNING_LIMIT:
                    rd_word[g] = vout_command[g] + (16'(ov_steps_q) << `STEP_SHIFT);
                `CMD_UV_WARNING_LIMIT:
                    rd_word[g] = vout_command[g] - (16'(uv_steps_q) << `STEP_SHIFT);
                default: rd_word[g] = 16'h0000;
            endcase
        end

        // Comparator levels come from the analog side and need two stages
        always_ff @(posedge clk) begin
            if (srst) begin
                sense_meta_q <= 3'h0;
                sense_s1_q <= 3'h0;
                sense_s2_q <= 3'h0;
            end else if (ce) begin
                sense_meta_q <= {ov_fault_sense[g], ov_warn_sense[g], uv_warn_sense[g]};
                sense_s1_q <= sense_meta_q;
                sense_s2_q <= sense_s1_q;
            end
        end

        assign ov_fault_rise = sense_s1_q[2] && !sense_s2_q[2];
        assign ov_warn_rise = sense_s1_q[1] && !sense_s2_q[1];
        assign uv_warn_rise = sense_s1_q[0] && !sense_s2_q[0];

        // Flags: fault summary, vout summary, fault, ov warn, uv warn, invalid
        // A new event beats a clear in the same cycle
        always_ff @(posedge clk) begin
            if (srst) begin
                flags_q <= 6'h00;
            end else if (ce) begin
                flags_q <= (status_clear[g] ? 6'h00 : flags_q) |
                           {ov_fault_rise, ov_fault_rise | ov_warn_rise | uv_warn_rise,
                            ov_fault_rise, ov_warn_rise, uv_warn_rise,
                            chan_bad[g]};
            end
        end

        // Latch-off holds until the rail is commanded off; hiccup also ends on a good start
        always_ff @(posedge clk) begin
            if (srst) begin
                shut_q <= 1'b0;
                retry_q <= 1'b0;
            end else if (ce) begin
                if (ov_fault_rise && action_q == `ACTION_SHUTDOWN) begin
                    shut_q <= 1'b1;
                end else if (!output_on[g]) begin
                    shut_q <= 1'b0;
                end else if (policy_q == `POLICY_HICCUP && startup_ok[g]) begin
                    shut_q <= 1'b0;
                end
                retry_q <= shut_q && output_on[g] && !startup_ok[g] && policy_q == `POLICY_HICCUP;
            end
        end

        assign ov_fault_summary_flag[g] = flags_q[5];
        assign vout_summary_flag[g] = flags_q[4];
        assign ov_fault_flag[g] = flags_q[3];
        assign ov_warning_flag[g] = flags_q[2];
        assign uv_warning_flag[g] = flags_q[1];
        assign invalid_data_flag[g] = flags_q[0];
        assign output_shutdown[g] = shut_q;
        assign hiccup_retry[g] = retry_q;
        assign ov_warning_value[g] = ov_steps_q;
        assign uv_warning_value[g] = uv_steps_q;
    end

    // ------------------------------------------------------------------------
    // Core answer and host notification
    // ------------------------------------------------------------------------
    // Answer words stay put until the next request, so the link may sample late
    always_ff @(posedge clk) begin
        if (srst) begin
            ack_tgl_q <= 1'b0;
            core_rdata_q <= 16'h0000;
            core_nack_q <= 1'b0;
        end else if (access) begin
            ack_tgl_q <= ~ack_tgl_q;
            core_rdata_q <= (l_write_q || page_bad) ? 16'h0000 : rd_word[rd_page];
            core_nack_q <= page_bad || code_bad || (|chan_bad);
        end
    end

    logic notify_q;

    // The notify line stays up while any page still holds a flag
    always_ff @(posedge clk) begin
        if (srst) begin
            notify_q <= 1'b0;
        end else if (ce) begin
            notify_q <= (|ov_fault_summary_flag) | (|vout_summary_flag) |
                        (|invalid_data_flag);
        end
    end

    assign notify_host = notify_q;

endmodule : vout_ov_uv_limit_commands

// file: tb/vout_limits_props.sv
`timescale 1ns/1ps
`include "vout_limits_params.svh"

module vout_limits_props
    import vout_limits_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic link_clk,
    input wire logic req_valid,
    input wire logic req_busy,
    input wire logic rsp_valid,
    input wire logic rsp_nack,
    input wire logic [`NUM_PAGES-1:0] ov_fault_sense,
    input wire logic [`NUM_PAGES-1:0] ov_warn_sense,
    input wire logic [`NUM_PAGES-1:0] uv_warn_sense,
    input wire logic [`NUM_PAGES-1:0] ov_fault_summary_flag,
    input wire logic [`NUM_PAGES-1:0] vout_summary_flag,
    input wire logic [`NUM_PAGES-1:0] ov_fault_flag,
    input wire logic [`NUM_PAGES-1:0] ov_warning_flag,
    input wire logic [`NUM_PAGES-1:0] uv_warning_flag,
    input wire logic [`NUM_PAGES-1:0] invalid_data_flag,
    input wire logic [`NUM_PAGES-1:0] output_shutdown,
    input wire logic [`NUM_PAGES-1:0] hiccup_retry,
    input wire logic [`NUM_PAGES-1:0][5:0] ov_warning_value,
    input wire logic [`NUM_PAGES-1:0][5:0] uv_warning_value,
    input wire logic ce,
    input wire logic notify_host
);
    logic any_flag;
    assign any_flag = |{ov_fault_summary_flag, vout_summary_flag, invalid_data_flag};

    chk_take_busy: assert property (@(posedge link_clk) disable iff (srst)
        req_valid && !req_busy |=> req_busy) else $error("request not taken");
    chk_answer_bound: assert property (@(posedge link_clk) disable iff (srst)
        req_valid && !req_busy |-> ##[1:12] rsp_valid) else $error("no answer");
    chk_answer_pulse: assert property (@(posedge link_clk) disable iff (srst)
        rsp_valid |=> !rsp_valid) else $error("answer longer than one cycle");
    chk_busy_drop: assert property (@(posedge link_clk) disable iff (srst)
        $fell(req_busy) |-> rsp_valid) else $error("busy dropped without answer");
    chk_fault_flags: assert property (@(posedge clk) disable iff (srst)
        $rose(ov_fault_sense[0]) |-> ##[1:4] (ov_fault_flag[0] && ov_fault_summary_flag[0]
        && vout_summary_flag[0])) else $error("fault flags missing");
    chk_ov_warn: assert property (@(posedge clk) disable iff (srst)
        $rose(ov_warn_sense[1]) |-> ##[1:4] (ov_warning_flag[1] && vout_summary_flag[1]))
        else $error("ov warning flags missing");
    chk_uv_warn: assert property (@(posedge clk) disable iff (srst)
        $rose(uv_warn_sense[0]) |-> ##[1:4] (uv_warning_flag[0] && vout_summary_flag[0]))
        else $error("uv warning flags missing");
    chk_notify_follow: assert property (@(posedge clk) disable iff (srst)
        ce |=> notify_host == $past(any_flag)) else $error("notify mismatch");
    chk_shut_cause: assert property (@(posedge clk) disable iff (srst)
        $rose(output_shutdown[0]) |-> ov_fault_flag[0]) else $error("shutdown without fault");
    chk_hiccup_shut: assert property (@(posedge clk) disable iff (srst)
        hiccup_retry[1] |-> output_shutdown[1]) else $error("hiccup while running");
    chk_offset_range: assert property (@(posedge clk) disable iff (srst)
        ov_warning_value[0] >= 1 && ov_warning_value[0] <= 56 && uv_warning_value[1] >= 1
        && uv_warning_value[1] <= 56) else $error("offset outside range");

    cover property (@(posedge link_clk) rsp_valid && rsp_nack);
    cover property (@(posedge clk) $rose(output_shutdown[0]));
    cover property (@(posedge clk) $rose(hiccup_retry[1]));
    cover property (@(posedge clk) $rose(invalid_data_flag[0]));
endmodule : vout_limits_props

bind vout_ov_uv_limit_commands vout_limits_props u_props (.clk(clk), .srst(srst),
    .link_clk(link_clk), .req_valid(req_valid), .req_busy(req_busy), .rsp_valid(rsp_valid),
    .rsp_nack(rsp_nack), .ov_fault_sense(ov_fault_sense), .ov_warn_sense(ov_warn_sense),
    .uv_warn_sense(uv_warn_sense), .ov_fault_summary_flag(ov_fault_summary_flag),
    .vout_summary_flag(vout_summary_flag), .ov_fault_flag(ov_fault_flag),
    .ov_warning_flag(ov_warning_flag), .uv_warning_flag(uv_warning_flag),
    .invalid_data_flag(invalid_data_flag), .output_shutdown(output_shutdown),
    .hiccup_retry(hiccup_retry), .ov_warning_value(ov_warning_value),
    .uv_warning_value(uv_warning_value), .ce(ce), .notify_host(notify_host));

// file: tb/host_model.sv
`timescale 1ns/1ps

module host_model (
    input wire logic link_clk,
    output logic req_valid,
    output logic req_write,
    output logic [7:0] req_code,
    output logic [7:0] req_page,
    output logic [15:0] req_wdata,
    input wire logic req_busy,
    input wire logic rsp_valid,
    input wire logic [15:0] rsp_rdata,
    input wire logic rsp_nack
);
    initial begin
        req_valid = 1'b0;
        req_write = 1'b0;
        req_code = 8'h00;
        req_page = 8'h00;
        req_wdata = 16'h0000;
    end

    // One transfer outstanding; released qualifiers are inverted so stale data never matches
    task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] p,
        input logic [15:0] wd, output logic [15:0] rd, output logic nk, output logic ok);
        int n;
        n = 0;
        ok = 1'b0;
        @(posedge link_clk);
        req_valid <= 1'b1;
        req_write <= w;
        req_code <= c;
        req_page <= p;
        req_wdata <= wd;
        @(posedge link_clk);
        req_valid <= 1'b0;
        req_write <= ~w;
        req_code <= ~c;
        req_page <= ~p;
        req_wdata <= ~wd;
        while (!ok && n < 20) begin
            @(posedge link_clk);
            ok = (rsp_valid === 1'b1);
            n++;
        end
        rd = rsp_rdata;
        nk = rsp_nack;
    endtask : xfer
endmodule : host_model

// file: tb/vout_ov_uv_limit_commands_tb.sv
`timescale 1ns/1ps
`include "vout_limits_params.svh"

module vout_ov_uv_limit_commands_tb
    import vout_limits_pkg::*;
;
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic req_valid, req_write, req_busy, rsp_valid, rsp_nack, notify_host, nk, ok, e;
    logic [7:0] req_code, req_page, c, p;
    word_t req_wdata, rsp_rdata, rd, d;
    logic [1:0][15:0] vcmd = {16'd1100, 16'd1000};
    logic [1:0][15:0] boot = {16'd900, 16'd900};
    logic [1:0] ovf_s = 0, ovw_s = 0, uvw_s = 0, out_on = 2'h3, st_ok = 0, st_clr = 0;
    logic [1:0] fsum, vsum, ovf, ovw, uvw, inv, shut, hic, inv_m;
    logic [1:0][5:0] ovv, uvv;
    int fails = 0;
    int check_count = 0;
    int ov_m[2], uv_m[2], act_m[2], i, off;
    logic [7:0] tbl[9] = '{8'h00, 8'h87, 8'hB8, 8'h40, 8'hC0, 8'h90, 8'h78, 8'h3F, 8'h80};

    always #10 clk = ~clk;
    always #40 link_clk = ~link_clk;

    vout_ov_uv_limit_commands DUT (.clk(clk), .srst(srst), .ce(ce), .link_clk(link_clk),
        .req_valid(req_valid), .req_write(req_write), .req_code(req_code), .req_page(req_page),
        .req_wdata(req_wdata), .req_busy(req_busy), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .rsp_nack(rsp_nack), .vout_command(vcmd),
        .boot_voltage_setting(boot), .ov_fault_sense(ovf_s), .ov_warn_sense(ovw_s),
        .uv_warn_sense(uvw_s), .output_on(out_on), .startup_ok(st_ok), .status_clear(st_clr),
        .ov_fault_summary_flag(fsum), .vout_summary_flag(vsum), .ov_fault_flag(ovf),
        .ov_warning_flag(ovw), .uv_warning_flag(uvw), .invalid_data_flag(inv),
        .output_shutdown(shut), .hiccup_retry(hic), .ov_warning_value(ovv),
        .uv_warning_value(uvv), .notify_host(notify_host));

    host_model host (.link_clk(link_clk), .req_valid(req_valid), .req_write(req_write),
        .req_code(req_code), .req_page(req_page), .req_wdata(req_wdata), .req_busy(req_busy),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_nack(rsp_nack));

    // ------------------------------------------------------------------------
    // Reference model and checks
    // ------------------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    function automatic logic [15:0] exp_rd(input logic [7:0] cc, input logic [7:0] pp);
        int q;
        q = (pp == 8'hFF) ? 0 : pp;
        if (cc == 8'h41) return 16'(act_m[q]);
        if (cc == 8'h42) return 16'(vcmd[q] + 8 * ov_m[q]);
        return 16'(vcmd[q] - 8 * uv_m[q]);
    endfunction : exp_rd

    // Broadcast writes judge each page on its own voltage command
    task automatic wr(input logic [7:0] cc, input logic [7:0] pp, input logic [15:0] dd);
        int q, diff;
        logic okv;
        logic [1:0] bad;
        bad = 2'h0;
        e = !(pp inside {8'h00, 8'h01, 8'hFF}) || !(cc inside {8'h41, 8'h42, 8'h43});
        for (q = 0; q < 2 && !e; q++) begin
            if (pp == q || pp == 8'hFF) begin
                diff = (cc == 8'h42) ? int'(dd) - int'(vcmd[q]) : int'(vcmd[q]) - int'(dd);
                if (cc == 8'h41) okv = !dd[6] && (dd[5:3] inside {3'h0, 3'h7});
                else okv = diff >= 8 && diff <= 448 && diff % 8 == 0;
                if (!okv) bad[q] = 1'b1;
                else if (cc == 8'h41) act_m[q] = dd & 16'h00F8;
                else if (cc == 8'h42) ov_m[q] = diff / 8;
                else uv_m[q] = diff / 8;
            end
        end
        inv_m = inv_m | bad;
        e = e || (|bad);
        host.xfer(1'b1, cc, pp, dd, rd, nk, ok);
        chk({14'h0, ok, nk}, {14'h0, 1'b1, e});
    endtask : wr

    task automatic rdc(input logic [7:0] cc, input logic [7:0] pp);
        host.xfer(1'b0, cc, pp, 16'h0000, rd, nk, ok);
        chk({15'h0, ok}, 16'h0001);
        chk(rd, exp_rd(cc, pp));
    endtask : rdc

    task automatic do_reset();
        srst <= 1'b1;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        inv_m = 2'h0;
        for (i = 0; i < 2; i++) begin
            act_m[i] = 8'hB8;
            ov_m[i] = (boot[i] == 0) ? 56 : 8;
            uv_m[i] = ov_m[i];
        end
        repeat (6) @(posedge link_clk);
    endtask : do_reset

    task automatic clear_flags();
        @(posedge clk);
        st_clr <= 2'h3;
        @(posedge clk);
        st_clr <= 2'h0;
        inv_m = 2'h0;
        repeat (3) @(posedge clk);
    endtask : clear_flags

    task automatic close_out();
        $display("checks=%0d fails=%0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out

    initial begin
        #400000;
        fails++;
        close_out();
    end

    initial begin
        void'($urandom(37));
        do_reset();
        rdc(8'h41, 8'h00);
        rdc(8'h42, 8'hFF);
        // Stimulus offsets run from -16 to 467, on both sides of the legal 8 to 448 range
        for (i = 0; i < 24; i++) begin
            p = (i % 3 == 2) ? 8'hFF : 8'($urandom_range(1));
            c = 8'h42 + 8'($urandom_range(1));
            off = $urandom_range(60) * 8 - 16 + ((i % 5 == 0) ? 3 : 0);
            d = (c == 8'h42) ? 16'(vcmd[p[0]] + off) : 16'(vcmd[p[0]] - off);
            wr(c, p, d);
            rdc(c, p);
            chk({14'h0, inv}, {14'h0, inv_m});
            chk({4'h0, ovv}, {4'h0, 6'(ov_m[1]), 6'(ov_m[0])});
            chk({4'h0, uvv}, {4'h0, 6'(uv_m[1]), 6'(uv_m[0])});
        end
        // Action byte changed only while no rail is shut down
        for (i = 0; i < 9; i++) begin
            wr(8'h41, (i % 2) ? 8'hFF : 8'h00, {8'h00, tbl[i]});
            rdc(8'h41, 8'h00);
            rdc(8'h41, 8'h01);
        end
        wr(8'h41, 8'h02, 16'h0080);
        wr(8'h44, 8'h00, 16'h0080);
        chk({14'h0, inv}, {14'h0, inv_m});
        @(posedge clk);
        vcmd <= {16'd1200, 16'd950};
        repeat (4) @(posedge clk);
        for (i = 0; i < 4; i++) rdc(8'h42 + 8'(i / 2), 8'(i % 2));
        chk({4'h0, ovv}, {4'h0, 6'(ov_m[1]), 6'(ov_m[0])});
        wr(8'h41, 8'h00, 16'h0080);
        wr(8'h41, 8'h01, 16'h00B8);
        clear_flags();
        chk({15'h0, notify_host}, 16'h0000);
        @(posedge clk);
        ovf_s <= 2'h3;
        repeat (6) @(posedge clk);
        chk({8'h00, fsum, vsum, ovf, shut}, 16'h00FF);
        chk({13'h0, notify_host, hic}, 16'h0006);
        ovf_s <= 2'h0;
        out_on[0] <= 1'b0;
        st_ok[1] <= 1'b1;
        repeat (4) @(posedge clk);
        chk({12'h0, shut, hic}, 16'h0000);
        out_on <= 2'h3;
        st_ok <= 2'h0;
        wr(8'h41, 8'h00, 16'h0000);
        clear_flags();
        ovf_s[0] <= 1'b1;
        ovw_s[1] <= 1'b1;
        uvw_s[0] <= 1'b1;
        repeat (6) @(posedge clk);
        chk({12'h0, ovf, shut}, 16'h0004);
        chk({10'h0, ovw, uvw, vsum}, 16'h0027);
        ce <= 1'b0;
        ovf_s[1] <= 1'b1;
        repeat (6) @(posedge clk);
        chk({12'h0, ovf, shut}, 16'h0004);
        ce <= 1'b1;
        boot[1] <= 16'h0000;
        do_reset();
        chk({4'h0, ovv}, {4'h0, 6'h38, 6'h08});
        chk({4'h0, uvv}, {4'h0, 6'h38, 6'h08});
        rdc(8'h42, 8'h01);
        rdc(8'h43, 8'h01);
        close_out();
    end
endmodule : vout_ov_uv_limit_commands_tb
